//--- logic/acs_pkg.sv
// What this block does
// (R01) done flag: 0 until completion, read only
// (R02) busy set at start, cleared at end/standby
// (R03) reading upper result clears done flag
// (R04) software reads status before upper result
// (R05) status bits 3..0 read undefined
// (R06) single mode: start bit launches one conversion
// (R07) completion loads result, done, interrupt together
// (R08) start bit self-clears once conversion begins
// (R09) software never restarts while converting
// (R10) repeat mode: each completion starts next
// (R11) mode 00 halts at once, drops result
// (R12) restart clears done, keeps old result
// (R13) standby aborts, resets controls, drops results
// (R14) no automatic restart after standby
// (R15) ladder disconnected throughout standby; here ladder_on drops one cycle after standby_req rises
// (R16) software programs controls before starting
// (R17) ten-bit result, low two bits in status
// (R18) upper result register holds bits 9..2
// (R19) controls held at reset, writes ignored, standby
// (R20) count selected clocks, one-cycle done pulse
`default_nettype none

package acs_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ACS_CTRL_ONE_ADDR   = 8'h0e;
    localparam logic [7:0] ACS_CTRL_TWO_ADDR   = 8'h0f;
    localparam logic [7:0] ACS_STATUS_ADDR     = 8'h20;
    localparam logic [7:0] ACS_RESULT_HI_ADDR  = 8'h21;

    localparam logic [7:0] ACS_CTRL_ONE_RESET  = 8'h10;
    localparam logic [7:0] ACS_CTRL_TWO_RESET  = 8'h10;
    localparam logic [9:0] ACS_RESULT_RESET    = 10'h000;

    // ==========================================================
    // operating modes
    localparam logic [1:0] ACS_MODE_OFF        = 2'h0;
    localparam logic [1:0] ACS_MODE_SINGLE     = 2'h1;
    localparam logic [1:0] ACS_MODE_REPEAT     = 2'h3;

    // ==========================================================
    // conversion lengths in system clock cycles, per time select
    localparam logic [10:0] ACS_CONV_CLKS_0    = 11'h027; // 39
    localparam logic [10:0] ACS_CONV_CLKS_2    = 11'h04e; // 78
    localparam logic [10:0] ACS_CONV_CLKS_3    = 11'h09c; // 156
    localparam logic [10:0] ACS_CONV_CLKS_4    = 11'h138; // 312
    localparam logic [10:0] ACS_CONV_CLKS_5    = 11'h270; // 624
    localparam logic [10:0] ACS_CONV_CLKS_6    = 11'h4e0; // 1248
    localparam logic [1:0]  ACS_STEP_LAST      = 2'h2;    // 3 clks a bit
    localparam logic [10:0] ACS_DECIDE_CLKS    = 11'h01e; // 10 bits x 3
    localparam logic [3:0]  ACS_MSB_INDEX      = 4'h9;

    // ==========================================================
    // register layouts, msb first
    typedef struct packed {
        logic       start;
        logic [1:0] mode;
        logic       input_disable;
        logic [3:0] channel;
    } acs_ctrl_one_t;

    typedef struct packed {
        logic [1:0] spare;
        logic       ladder_keep;
        logic       fixed_one;
        logic [2:0] time_sel;
        logic       fixed_zero;
    } acs_ctrl_two_t;

    typedef struct packed {
        logic [1:0] result_low;
        logic       done;
        logic       busy;
        logic [3:0] filler;
    } acs_status_t;

    // drive bundle toward sample-hold, ladder and comparator
    typedef struct packed {
        logic [3:0] channel;
        logic       input_disable;
        logic       sample_en;
        logic       ladder_on;
        logic [9:0] trial;
    } acs_analog_t;

endpackage

`default_nettype wire

//--- logic/acs_top.sv
// Chosen here: strobed register access.
`default_nettype none

module acs_top (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output var  logic [7:0]             reg_rdata,
    input  wire logic                   standby_req,
    input  wire logic                   cmp_above,
    output var  acs_pkg::acs_analog_t   analog_drive,
    output var  logic                   conv_done_irq
);
    import acs_pkg::*;

    // idle, sample window, then three cycles per bit decision
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_SAMPLE,
        ACS_DECIDE
    } acs_state_t;

    // ==========================================================
    // state
    acs_ctrl_one_t ctrl_one_q;
    acs_ctrl_one_t ctrl_one_d;
    acs_ctrl_two_t ctrl_two_q;
    acs_ctrl_two_t ctrl_two_d;
    acs_state_t    state_q;
    acs_state_t    state_d;
    logic [10:0]   cnt_q;
    logic [10:0]   cnt_d;
    logic [1:0]    step_q;
    logic [1:0]    step_d;
    logic [3:0]    bit_q;
    logic [3:0]    bit_d;
    logic [9:0]    trial_q;
    logic [9:0]    trial_d;
    logic [9:0]    result_q;
    logic          done_q;
    logic          busy_q;
    logic          cmp_meta_q;
    logic          cmp_sync_q;
    logic [7:0]    rdata_q;
    logic          irq_q;
    acs_analog_t   drive_q;
    acs_analog_t   drive_d;

    // ==========================================================
    // bus decode
    // status and upper result are read only: writes there match nothing
    wire wr_one     = reg_wr && (reg_addr == ACS_CTRL_ONE_ADDR);
    wire wr_two     = reg_wr && (reg_addr == ACS_CTRL_TWO_ADDR);
    wire rd_status  = reg_rd && (reg_addr == ACS_STATUS_ADDR);
    wire rd_one     = reg_rd && (reg_addr == ACS_CTRL_ONE_ADDR);
    wire rd_two     = reg_rd && (reg_addr == ACS_CTRL_TWO_ADDR);
    wire rd_res_hi  = reg_rd && (reg_addr == ACS_RESULT_HI_ADDR);

    acs_ctrl_one_t wdata_one;
    assign wdata_one = acs_ctrl_one_t'(reg_wdata);

    // ==========================================================
    // sequencing conditions
    wire mode_run   = (ctrl_one_q.mode == ACS_MODE_SINGLE)
                   || (ctrl_one_q.mode == ACS_MODE_REPEAT);
    // a write of mode 00 halts in the same edge it lands
    wire off_write  = wr_one && (wdata_one.mode == ACS_MODE_OFF);
    wire halt       = standby_req || off_write                 // [R11]
                   || (ctrl_one_q.mode == ACS_MODE_OFF);       // [R13]
    wire start_go   = ctrl_one_q.start && mode_run && !halt;   // [R06]
    // a start written with mode 00 or 10 is dropped, nothing runs
    wire start_drop = ctrl_one_q.start && !mode_run;
    wire last_step  = (state_q == ACS_DECIDE)
                   && (step_q == ACS_STEP_LAST);
    wire finish     = last_step && (bit_q == 4'h0)
                   && !halt && !start_go;                      // [R20]
    wire repeat_on  = ctrl_one_q.mode == ACS_MODE_REPEAT;

    // trial word after the decision on the current bit
    // a high comparator keeps the bit, a low one clears it
    wire [9:0] bit_mask = 10'h001 << bit_q;
    wire [9:0] decided  = cmp_sync_q ? trial_q
                                     : (trial_q & ~bit_mask);
    wire [9:0] msb_only = 10'h001 << ACS_MSB_INDEX;

    // ==========================================================
    // conversion length from the time select field
    // reserved codes fall back to the longest, slowest conversion
    logic [10:0] conv_clks;
    always_comb begin
        case (ctrl_two_q.time_sel)
            3'h0:    conv_clks = ACS_CONV_CLKS_0;
            3'h2:    conv_clks = ACS_CONV_CLKS_2;
            3'h3:    conv_clks = ACS_CONV_CLKS_3;
            3'h4:    conv_clks = ACS_CONV_CLKS_4;
            3'h5:    conv_clks = ACS_CONV_CLKS_5;
            default: conv_clks = ACS_CONV_CLKS_6; // reserved: longest
        endcase
    end

    // sample window takes what the bit decisions leave over
    wire [10:0] sample_load = conv_clks - ACS_DECIDE_CLKS - 11'h001;

    // ==========================================================
    // sequencer next state
    // a conversion is a sample window of sample_load + 1 cycles, then
    // three cycles per bit; the third cycle reads the comparator answer
    // for the trial, which needs the two synchroniser stages to settle.
    // halt and a fresh start override whichever phase is running
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        step_d  = step_q;
        bit_d   = bit_q;
        trial_d = trial_q;
        if (halt) begin
            state_d = ACS_IDLE;                        // [R11] [R13]
            trial_d = ACS_RESULT_RESET;
        end else if (start_go) begin
            state_d = ACS_SAMPLE;                      // [R06] [R20]
            cnt_d   = sample_load;
            trial_d = ACS_RESULT_RESET;
        end else begin
            case (state_q)
                ACS_IDLE: begin
                    state_d = ACS_IDLE;                // [R14]
                end
                ACS_SAMPLE: begin
                    if (cnt_q == 11'h000) begin
                        state_d = ACS_DECIDE;
                        step_d  = 2'h0;
                        bit_d   = ACS_MSB_INDEX;
                        trial_d = msb_only;
                    end else begin
                        cnt_d = cnt_q - 11'h001;       // [R20]
                    end
                end
                ACS_DECIDE: begin
                    if (!last_step) begin
                        step_d = step_q + 2'h1;
                    end else if (bit_q == 4'h0) begin
                        trial_d = decided;
                        if (repeat_on) begin
                            state_d = ACS_SAMPLE;      // [R10]
                            cnt_d   = sample_load;
                        end else begin
                            state_d = ACS_IDLE;
                        end
                    end else begin
                        step_d  = 2'h0;
                        bit_d   = bit_q - 4'h1;
                        trial_d = decided | (bit_mask >> 1);
                    end
                end
                default: begin
                    state_d = ACS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // control registers: writes, self-clearing start, standby hold
    // a write landing with the self-clear keeps the written value
    always_comb begin
        ctrl_one_d = ctrl_one_q;
        ctrl_two_d = ctrl_two_q;
        if (standby_req) begin
            ctrl_one_d = acs_ctrl_one_t'(ACS_CTRL_ONE_RESET); // [R19]
            ctrl_two_d = acs_ctrl_two_t'(ACS_CTRL_TWO_RESET); // [R13]
        end else begin
            if (start_go || start_drop) begin
                ctrl_one_d.start = 1'b0;                      // [R08]
            end
            if (wr_one) begin
                ctrl_one_d = wdata_one;
            end
            if (wr_two) begin
                ctrl_two_d = acs_ctrl_two_t'(reg_wdata);
            end
        end
    end

    // ==========================================================
    // analog drive, registered toward the macro
    // registered so trial and sample window change on one edge
    always_comb begin
        drive_d               = drive_q;
        drive_d.channel       = ctrl_one_d.channel;
        drive_d.input_disable = ctrl_one_d.input_disable;
        drive_d.sample_en     = state_d == ACS_SAMPLE;
        drive_d.ladder_on     = !standby_req                 // [R15]
                             && (ctrl_two_d.ladder_keep
                             || (state_d != ACS_IDLE));
        drive_d.trial         = trial_d;
    end

    // ==========================================================
    // read mux; status bits 3..0 return zero
    // unmapped addresses and control two bits 7..6 read zero
    acs_status_t status_view;
    assign status_view.result_low = result_q[1:0];            // [R17]
    assign status_view.done       = done_q;                   // [R01]
    assign status_view.busy       = busy_q;                   // [R02]
    assign status_view.filler     = 4'h0;                     // [R05]

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (rd_status) begin
            rd_mux = status_view;
        end else if (rd_res_hi) begin
            rd_mux = result_q[9:2];                           // [R18]
        end else if (rd_one) begin
            rd_mux = ctrl_one_q;
        end else if (rd_two) begin
            rd_mux = {2'h0, ctrl_two_q[5:0]};
        end
    end

    // ==========================================================
    // comparator synchroniser, first stage feeds only the second
    // the comparator output has no relation to ref_clk edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            cmp_meta_q <= cmp_above;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // ==========================================================
    // sequencer and control registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q    <= ACS_IDLE;
            cnt_q      <= 11'h000;
            step_q     <= 2'h0;
            bit_q      <= 4'h0;
            trial_q    <= ACS_RESULT_RESET;
            ctrl_one_q <= acs_ctrl_one_t'(ACS_CTRL_ONE_RESET);
            ctrl_two_q <= acs_ctrl_two_t'(ACS_CTRL_TWO_RESET);
            busy_q     <= 1'b0;
            drive_q    <= '0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            step_q     <= step_d;
            bit_q      <= bit_d;
            trial_q    <= trial_d;
            ctrl_one_q <= ctrl_one_d;
            ctrl_two_q <= ctrl_two_d;
            busy_q     <= state_d != ACS_IDLE;                // [R02]
            drive_q    <= drive_d;
        end
    end

    // ==========================================================
    // result, done flag and completion pulse
    // standby clears the result so no stale value survives wake-up
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result_q <= ACS_RESULT_RESET;
            done_q   <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            irq_q <= finish;                                  // [R07] [R20]
            if (standby_req) begin
                result_q <= ACS_RESULT_RESET;                 // [R13]
            end else if (finish) begin
                result_q <= decided;                          // [R07] [R12]
            end
            // completion wins over a clearing read in the same cycle
            if (finish) begin
                done_q <= 1'b1;                               // [R01] [R07]
            end else if (rd_res_hi) begin
                done_q <= 1'b0;                               // [R03] [R04]
            end else if (start_go || standby_req) begin
                done_q <= 1'b0;                               // [R12]
            end
        end
    end

    // ==========================================================
    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_mux;
        end
    end

    // every output comes straight from its flip-flop
    assign reg_rdata     = rdata_q;
    assign analog_drive  = drive_q;
    assign conv_done_irq = irq_q;

endmodule

`default_nettype wire

//--- verif/acs_cmp_model.sv
`default_nettype none

// ==========================================================
// comparator partner: held input level against the trial word
module acs_cmp_model
    import acs_pkg::*;
(
    input  wire acs_pkg::acs_analog_t analog_drive,
    input  wire logic [9:0]           level,
    output logic                      cmp_above
);
    // ideal comparator, high while the input reaches the trial
    assign cmp_above = level >= analog_drive.trial;
endmodule

`default_nettype wire

//--- verif/acs_assertions.sv
`default_nettype none

// ==========================================================
// port checks for the conversion sequencer
module acs_assertions
    import acs_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_rdata,
    input  wire logic                 standby_req,
    input  wire logic                 cmp_above,
    input  wire acs_pkg::acs_analog_t analog_drive,
    input  wire logic                 conv_done_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // decoded strobes
    wire logic ctl_wr = reg_wr && reg_addr == ACS_CTRL_ONE_ADDR;
    wire logic sta_rd = reg_rd && reg_addr == ACS_STATUS_ADDR;

    // ==========================================================
    // assertions
    irq_pulse_a: assert property (conv_done_irq |=> !conv_done_irq)
        else $error("done pulse longer than one cycle");
    ladder_off_a: assert property (
        standby_req && $past(standby_req) |-> !analog_drive.ladder_on)
        else $error("ladder connected in standby");
    standby_irq_a: assert property (
        standby_req && $past(standby_req) |-> !conv_done_irq)
        else $error("completion during standby");
    busy_clear_a: assert property (
        standby_req && $past(standby_req) && sta_rd
        |=> reg_rdata[5:4] == 2'h0) else $error("busy or done in standby");
    ctrl_held_a: assert property (
        standby_req && $past(standby_req) && reg_rd
        && reg_addr == ACS_CTRL_ONE_ADDR |=> reg_rdata == ACS_CTRL_ONE_RESET)
        else $error("control one not held in standby");
    filler_zero_a: assert property (
        $past(sta_rd) |-> reg_rdata[3:0] == 4'h0)
        else $error("status low bits not zero");
    halt_quiet_a: assert property (
        ctl_wr && reg_wdata[6:5] == ACS_MODE_OFF
        |-> ##2 !conv_done_irq [*8]) else $error("completion after halt");
    start_sample_a: assert property (
        ctl_wr && reg_wdata[7] && reg_wdata[6:5] == ACS_MODE_SINGLE
        && !standby_req |-> ##[1:3] analog_drive.sample_en)
        else $error("start did not open sampling");

    // main scenarios
    cv_irq: cover property (conv_done_irq);
    cv_stby: cover property (standby_req && $past(standby_req) && sta_rd);
    cv_rep: cover property (ctl_wr && reg_wdata[7:5] == 3'h7);
endmodule

`default_nettype wire

//--- verif/acs_top_tb.sv
`default_nettype none

// ==========================================================
// self-checking bench for the conversion sequencer
module acs_top_tb import acs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        standby_req = 1'b0;
    logic [9:0]  target = 10'h2b5;
    wire logic [7:0] reg_rdata;
    wire logic   cmp_above;
    wire logic   conv_done_irq;
    acs_analog_t analog_drive;
    // analog controls seen by the macro: ladder, sample, disable, channel
    wire logic [7:0] drive_view = {1'b0, analog_drive.ladder_on,
        analog_drive.sample_en, analog_drive.input_disable,
        analog_drive.channel};
    int          fail_count = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          irq_count = 0;
    int          n;
    int          snap;
    logic [2:0]  tsel [8] = '{3'h0, 3'h2, 3'h3, 3'h4,
                              3'h5, 3'h6, 3'h1, 3'h7};
    int          nclk [8] = '{39, 78, 156, 312, 624, 1248, 1248, 1248};
    logic [9:0]  tgt [8] = '{10'h2b5, 10'h14a, 10'h001, 10'h3fe,
                             10'h200, 10'h1ff, 10'h0d3, 10'h3c6};

    acs_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .standby_req(standby_req),
        .cmp_above(cmp_above), .analog_drive(analog_drive),
        .conv_done_irq(conv_done_irq));
    acs_cmp_model u_cmp (.analog_drive(analog_drive), .level(target),
        .cmp_above(cmp_above));

    // clock, cycle limit and completion count
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (conv_done_irq === 1'b1) irq_count++;
        if (cycles == 12000) begin
            fail_count++;
            summarize();
        end
    end

    // ==========================================================
    // compare, bus and wait tasks
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic checkn(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check8(reg_rdata, exp);
    endtask
    task automatic wait_irq(output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (conv_done_irq !== 1'b1 && k < 2000);
    endtask
    task automatic summarize();
        $display("checks=%0d failures=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(ACS_CTRL_ONE_ADDR, ACS_CTRL_ONE_RESET);
        rd(ACS_CTRL_TWO_ADDR, ACS_CTRL_TWO_RESET);
        wr(ACS_STATUS_ADDR, 8'hff);
        rd(ACS_STATUS_ADDR, 8'h00);
        rd(8'h33, 8'h00);
        // single conversions over the conversion lengths
        for (int i = 0; i < 8; i++) begin
            target = tgt[i];
            wr(ACS_CTRL_ONE_ADDR, 8'h21);
            wr(ACS_CTRL_TWO_ADDR, {4'h1, tsel[i], 1'b0});
            wr(ACS_CTRL_ONE_ADDR, 8'ha1);
            wait_irq(n);
            checkn(n, nclk[i] - 1, nclk[i] + 3);
            check8(drive_view, 8'h01);
            rd(ACS_STATUS_ADDR, {tgt[i][1:0], 6'h20});
            rd(ACS_RESULT_HI_ADDR, tgt[i][9:2]);
            rd(ACS_STATUS_ADDR, {tgt[i][1:0], 6'h00});
            rd(ACS_CTRL_ONE_ADDR, 8'h21);
        end
        // restart before the result is read
        wr(ACS_CTRL_TWO_ADDR, 8'h10);
        wr(ACS_CTRL_ONE_ADDR, 8'ha1);
        wait_irq(n);
        target = 10'h019;
        wr(ACS_CTRL_ONE_ADDR, 8'ha1);
        rd(ACS_STATUS_ADDR, 8'h90);
        rd(ACS_RESULT_HI_ADDR, 8'hf1);
        wait_irq(n);
        rd(ACS_STATUS_ADDR, 8'h60);
        // repeat mode, then halt mid conversion
        wr(ACS_CTRL_ONE_ADDR, 8'h61);
        wr(ACS_CTRL_ONE_ADDR, 8'he1);
        wait_irq(n);
        target = 10'h2aa;
        wait_irq(n);
        checkn(n, 37, 43);
        target = 10'h3ff;
        wr(ACS_CTRL_ONE_ADDR, 8'h01);
        snap = irq_count;
        repeat (200) @(posedge ref_clk);
        checkn(irq_count - snap, 0, 0);
        rd(ACS_RESULT_HI_ADDR, 8'haa);
        // standby in mid conversion
        wr(ACS_CTRL_ONE_ADDR, 8'h21);
        wr(ACS_CTRL_ONE_ADDR, 8'ha1);
        repeat (5) @(posedge ref_clk);
        standby_req <= 1'b1;
        #1;
        check8(drive_view, 8'h61);
        snap = irq_count;
        wr(ACS_CTRL_ONE_ADDR, 8'ha1);
        rd(ACS_CTRL_ONE_ADDR, ACS_CTRL_ONE_RESET);
        rd(ACS_CTRL_TWO_ADDR, ACS_CTRL_TWO_RESET);
        rd(ACS_STATUS_ADDR, 8'h00);
        rd(ACS_RESULT_HI_ADDR, 8'h00);
        check8(drive_view, 8'h10);
        @(posedge ref_clk);
        standby_req <= 1'b0;
        repeat (100) @(posedge ref_clk);
        checkn(irq_count - snap, 0, 0);
        rd(ACS_CTRL_ONE_ADDR, ACS_CTRL_ONE_RESET);
        summarize();
    end
endmodule

bind acs_top acs_assertions u_chk (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_req(standby_req),
    .cmp_above(cmp_above), .analog_drive(analog_drive),
    .conv_done_irq(conv_done_irq));

`default_nettype wire
